/* File: src/spo_map.vh */
`ifndef SPO_MAP_VH
`define SPO_MAP_VH

// Operation select codes
`define SPO_OP_MADD     3'h0
`define SPO_OP_QADD     3'h1
`define SPO_OP_QSUB     3'h2
`define SPO_OP_SHL      3'h3
`define SPO_OP_SHR      3'h4
`define SPO_OP_TEST     3'h5
`define SPO_OP_BLEND    3'h6

// Field sizes
`define SPO_WORD_W      16
`define SPO_DWORD_W     32
`define SPO_QWORD_W     64
`define SPO_REG_W       128
`define SPO_SHIFT_MAX   8'h0f

// Reset values
`define SPO_RESULT_RST  128'h0
`define SPO_FLAG_RST    1'b0

`endif

/* File: src/spo_lane64.v */
// Wrapping 64-bit add or subtract lane
module spo_lane64 #(
    parameter W = 64
) (
    input  wire [W-1:0] a_i,
    input  wire [W-1:0] b_i,
    input  wire         sub_i,
    output wire [W-1:0] sum_o
);
    // Same adder for signed and unsigned operands, low bits kept
    assign sum_o = sub_i ? (a_i - b_i) : (a_i + b_i);
endmodule

/* File: src/spo_alu.v */
// Operation
// - Word multiply-add forms four signed 16-bit products and two sums per 64 bits, packed doublewords.
// - Duplicated data gives real DR*CR-DI*CI and imaginary DR*CI+DI*CR.
// - Complex product returns as two 32-bit doublewords in one 64-bit register.
// - Quadword add and subtract treat signed and unsigned operands identically.
// - Overflowing quadword results keep only low 64 bits, wrapping without saturation.
// - The 128-bit form performs two independent quadword operations, low and high.
// - Byte shifts move the operand by the immediate count, zero filling.
// - A shift count above 15 clears the whole destination.
// - Wide logical test updates the zero and carry flags.
`include "spo_map.vh"

module spo_alu #(
    parameter REG_W = 128
) (
    input  wire             CORE_CLK_I,
    input  wire             RST_N_I,
    input  wire             START_I,
    input  wire [2:0]       OP_I,
    input  wire             WIDE_I,
    input  wire [REG_W-1:0] SRC_A_I,
    input  wire [REG_W-1:0] SRC_B_I,
    input  wire [REG_W-1:0] MASK_I,
    input  wire [7:0]       IMM_I,
    output reg  [REG_W-1:0] RESULT_O,
    output reg              ZERO_FLAG_O,
    output reg              CARRY_FLAG_O,
    output reg              DONE_O
);
    localparam NDW = REG_W / `SPO_DWORD_W;
    localparam NQW = REG_W / `SPO_QWORD_W;

    wire [REG_W-1:0] madd_res;
    wire [REG_W-1:0] quad_res;
    wire [REG_W-1:0] blend_res;
    wire [REG_W-1:0] half_mask;
    wire [REG_W-1:0] shl_res;
    wire [REG_W-1:0] shr_res;
    wire [6:0]       shift_bits;
    wire             shift_over;

    reg  [REG_W-1:0] result_d;
    reg              zero_d;
    reg              carry_d;

    // Narrow form keeps only the low 64 bits
    assign half_mask = WIDE_I ? {REG_W{1'b1}} : {{(REG_W-`SPO_QWORD_W){1'b0}}, {`SPO_QWORD_W{1'b1}}};

    genvar k;
    generate
        for (k = 0; k < NDW; k = k + 1) begin : g_dw
            wire signed [15:0] a_lo;
            wire signed [15:0] a_hi;
            wire signed [15:0] b_lo;
            wire signed [15:0] b_hi;
            wire signed [31:0] p_lo;
            wire signed [31:0] p_hi;
            wire        [31:0] dsum;
            assign a_lo = SRC_A_I[32*k+15:32*k];
            assign a_hi = SRC_A_I[32*k+31:32*k+16];
            assign b_lo = SRC_B_I[32*k+15:32*k];
            assign b_hi = SRC_B_I[32*k+31:32*k+16];
            // Two signed products summed per doubleword
            assign p_lo = a_lo * b_lo;
            assign p_hi = a_hi * b_hi;
            // With [DR DI DR DI] and [CR -CI CI CR] gives real and imaginary parts
            assign dsum = p_lo + p_hi;
            assign madd_res[32*k+31:32*k] = dsum;
            // Mask sign bit picks second source lane
            assign blend_res[32*k+31:32*k] = MASK_I[32*k+31] ?
                SRC_B_I[32*k+31:32*k] : SRC_A_I[32*k+31:32*k];
        end
        for (k = 0; k < NQW; k = k + 1) begin : g_qw
            // Independent lane per quadword
            spo_lane64 #(
                .W (`SPO_QWORD_W)
            ) u_lane (
                .a_i   (SRC_A_I[64*k+63:64*k]),
                .b_i   (SRC_B_I[64*k+63:64*k]),
                .sub_i (OP_I == `SPO_OP_QSUB),
                .sum_o (quad_res[64*k+63:64*k])
            );
        end
    endgenerate

    // Byte count to bit count, oversize count clears
    assign shift_bits = {IMM_I[3:0], 3'h0};
    assign shift_over = (IMM_I > `SPO_SHIFT_MAX);
    assign shl_res    = shift_over ? {REG_W{1'b0}} : ((SRC_A_I & half_mask) << shift_bits);
    assign shr_res    = shift_over ? {REG_W{1'b0}} : ((SRC_A_I & half_mask) >> shift_bits);

    always @* begin
        result_d = RESULT_O;
        zero_d   = ZERO_FLAG_O;
        carry_d  = CARRY_FLAG_O;
        case (OP_I)
            `SPO_OP_MADD: begin
                result_d = madd_res & half_mask;
            end
            `SPO_OP_QADD,
            `SPO_OP_QSUB: begin
                result_d = quad_res & half_mask;
            end
            `SPO_OP_SHL: begin
                result_d = shl_res & half_mask;
            end
            `SPO_OP_SHR: begin
                result_d = shr_res;
            end
            `SPO_OP_TEST: begin
                // Flags only, destination untouched
                zero_d  = ~|(SRC_A_I & SRC_B_I);
                carry_d = ~|(SRC_B_I & ~SRC_A_I);
            end
            `SPO_OP_BLEND: begin
                result_d = blend_res & half_mask;
            end
            default: begin
                result_d = RESULT_O;
            end
        endcase
    end

    always @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            RESULT_O     <= `SPO_RESULT_RST;
            ZERO_FLAG_O  <= `SPO_FLAG_RST;
            CARRY_FLAG_O <= `SPO_FLAG_RST;
            DONE_O       <= 1'b0;
        end else begin
            DONE_O <= START_I;
            if (START_I) begin
                RESULT_O     <= result_d;
                ZERO_FLAG_O  <= zero_d;
                CARRY_FLAG_O <= carry_d;
            end
        end
    end
endmodule

/* File: testbench/spo_alu_assertions.sv */
module spo_alu_checker #(
    parameter REG_W = 128
) (
    input logic             CORE_CLK_I,
    input logic             RST_N_I,
    input logic             START_I,
    input logic [2:0]       OP_I,
    input logic             WIDE_I,
    input logic [REG_W-1:0] SRC_A_I,
    input logic [REG_W-1:0] SRC_B_I,
    input logic [REG_W-1:0] MASK_I,
    input logic [7:0]       IMM_I,
    input logic [REG_W-1:0] RESULT_O,
    input logic             ZERO_FLAG_O,
    input logic             CARRY_FLAG_O,
    input logic             DONE_O
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_N_I);
    logic [REG_W-1:0] a_q;
    logic [REG_W-1:0] b_q;
    always @(posedge CORE_CLK_I) begin
        a_q <= SRC_A_I;
        b_q <= SRC_B_I;
    end
    qadd_low_a: assert property (START_I && OP_I == 3'h1 |=> RESULT_O[63:0] == a_q[63:0] + b_q[63:0]) else $error("qadd");
    qsub_high_a: assert property (START_I && OP_I == 3'h2 && WIDE_I |=> RESULT_O[127:64] == a_q[127:64] - b_q[127:64]) else $error("qsub");
    shift_clear_a: assert property (START_I && (OP_I == 3'h3 || OP_I == 3'h4) && IMM_I > 8'h0f |=> RESULT_O == '0) else $error("clear");
    shl_fill_a: assert property (START_I && OP_I == 3'h3 && IMM_I != 8'h00 |=> RESULT_O[7:0] == 8'h00) else $error("shl");
    shr_fill_a: assert property (START_I && OP_I == 3'h4 && IMM_I != 8'h00 |=> RESULT_O[127:120] == 8'h00) else $error("shr");
    zero_flag_a: assert property (START_I && OP_I == 3'h5 |=> ZERO_FLAG_O == ~|(a_q & b_q)) else $error("zero");
    carry_flag_a: assert property (START_I && OP_I == 3'h5 |=> CARRY_FLAG_O == ~|(b_q & ~a_q)) else $error("carry");
    flags_hold_a: assert property (START_I && OP_I != 3'h5 |=> $stable(ZERO_FLAG_O) && $stable(CARRY_FLAG_O)) else $error("flags");
endmodule
bind spo_alu spo_alu_checker #(.REG_W(REG_W)) spo_alu_checker_inst (.CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I),
    .START_I(START_I), .OP_I(OP_I), .WIDE_I(WIDE_I), .SRC_A_I(SRC_A_I), .SRC_B_I(SRC_B_I), .MASK_I(MASK_I),
    .IMM_I(IMM_I), .RESULT_O(RESULT_O), .ZERO_FLAG_O(ZERO_FLAG_O), .CARRY_FLAG_O(CARRY_FLAG_O), .DONE_O(DONE_O));

/* File: testbench/testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic         clk = 1'b0, rst_n = 1'b0, go = 1'b0, w = 1'b0, zf, cf, dn;
    logic [2:0]   o = 3'h7, ef = 3'h0;
    logic [7:0]   i8 = 8'h00;
    logic [127:0] x = '0, y = '0, m = '0, r, e = '0, wa, t, u;
    logic [31:0]  s = 32'h51, p;
    int           mismatches = 0, checks = 0;
    spo_alu spo_alu_inst (.CORE_CLK_I(clk), .RST_N_I(rst_n), .START_I(go), .OP_I(o), .WIDE_I(w), .SRC_A_I(x),
        .SRC_B_I(y), .MASK_I(m), .IMM_I(i8), .RESULT_O(r), .ZERO_FLAG_O(zf), .CARRY_FLAG_O(cf), .DONE_O(dn));
    function automatic logic [31:0] xs();
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    task automatic chk(input string n, input logic [127:0] ex, got);
        checks++;
        if (ex !== got) begin
            mismatches++;
            $display("MISMATCH %s exp %h got %h", n, ex, got);
        end
    endtask
    task automatic stop_test();
        if (mismatches == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial forever #20 clk = ~clk;
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (int n = 0; n < 4000; n++) begin
            @(posedge clk);
            p = xs();
            t = n == 0 ? {8{16'h8000}} : {xs(), xs(), xs(), xs()};
            u = n == 0 ? t : {xs(), xs(), xs(), xs()};
            if (n == 1) begin
                t = {64'h0, 16'h0003, 16'h0002, 16'h0003, 16'h0002};
                u = {64'h0, 16'h0005, 16'h0004, 16'hfffc, 16'h0005};
            end
            if (p[4:2] == 3'h5 && n > 1)
                u = p[13] ? u & ~t : u & t;
            go <= p[1:0] != 2'b00 || n < 2;
            o <= n < 2 ? 3'h0 : p[4:2];
            w <= p[5] || n == 0;
            i8 <= {3'b000, p[12:8]};
            x <= t;
            y <= u;
            m <= {xs(), xs(), xs(), xs()};
            @(negedge clk);
            chk("done", ef[2], dn);
            chk("result", e, r);
            chk("zero", ef[1], zf);
            chk("carry", ef[0], cf);
            if (n == 2)
                chk("complex", {64'h0, 32'h00000017, 32'hfffffffe}, r);
            ef[2] = go;
            wa = w ? x : {64'h0, x[63:0]};
            if (go)
                case (o)
                    3'h0: for (int k = 0; k < 128; k += 32) begin
                        p = $signed(x[k+:16]) * $signed(y[k+:16]) + $signed(x[k+16+:16]) * $signed(y[k+16+:16]);
                        e[k+:32] = p;
                    end
                    3'h1: e = {x[127:64] + y[127:64], x[63:0] + y[63:0]};
                    3'h2: e = {x[127:64] - y[127:64], x[63:0] - y[63:0]};
                    3'h3: e = i8 > 15 ? '0 : wa << 8 * i8;
                    3'h4: e = i8 > 15 ? '0 : wa >> 8 * i8;
                    3'h5: ef[1:0] = {~|(x & y), ~|(y & ~x)};
                    3'h6: for (int k = 0; k < 128; k += 32) e[k+:32] = m[k+31] ? y[k+:32] : x[k+:32];
                    default: ;
                endcase
            if (go && !w && o != 3'h5 && o != 3'h7)
                e[127:64] = '0;
        end
        stop_test();
    end
endmodule
